// ==== pkg/cfa_consts.svh ====
// constants of the core, its fetch path and its data address decoder
// Operation
// - fetch the next instruction while the current one executes, one per clock
// - program and data memories are separate spaces on separate buses
// - thirty-two 8-bit working registers, read and written in one cycle
// - register-register (except multiply), register-immediate and single-register operations finish in one cycle
// - every arithmetic or logic operation updates the status flags from its result
// - six registers pair into three 16-bit pointers for data and program space
// - all peripheral registers decode inside the lowest 4KB of data space
// - locations 0x00 to 0x3F reachable by direct I/O and as data space; RAMP at 0x3B is only written, by direct I/O output
// - locations 0x0040 to 0x0FFF reachable only by data loads and stores
// - data addresses 0x1000 to 0x1FFF select the EEPROM window
// - SRAM starts at 0x2000 and is reachable by all five addressing modes
// - instructions are fetched only from program memory, never from SRAM
// - program and data addresses are 24 bits, reaching 16MB each
// - 16-bit and 24-bit I/O registers are accessed as one whole transfer
// - application and boot sections each have write and read/write lock bits
// - the application table subsection has its own write and read/write lock bits
// - self-programming changes application flash only when executed from the boot section
// - 8 by 8 multiply gives a 16-bit result in two clocks
`ifndef CFA_CONSTS_SVH
`define CFA_CONSTS_SVH

`define CFA_IO_LAST 24'h000fff
`define CFA_DIRECT_IO_LAST 24'h00003f
`define CFA_EEP_FIRST 24'h001000
`define CFA_EEP_LAST 24'h001fff
`define CFA_SRAM_FIRST 24'h002000
`define CFA_RAMP_IO 6'h3b
`define CFA_NOP 16'h0000
`define CFA_PC_RST 24'h000000
`define CFA_PTR_BASE 5'h1a
`define CFA_OP_NOP 4'h0
`define CFA_OP_ADD 4'h1
`define CFA_OP_SUB 4'h2
`define CFA_OP_AND 4'h3
`define CFA_OP_EOR 4'h4
`define CFA_OP_LDI 4'h5
`define CFA_OP_SUBI 4'h6
`define CFA_OP_UNARY 4'h7
`define CFA_OP_MUL 4'h8
`define CFA_OP_LOAD 4'h9
`define CFA_OP_STORE 4'ha
`define CFA_OP_IO 4'hb
`define CFA_OP_LPM 4'hc
`define CFA_OP_SPM 4'hd
`define CFA_OP_JMP 4'he
`define CFA_OP_BREQ 4'hf

`endif

// ==== pkg/cfa_pkg.sv ====
// types shared by the core and its bench
package cfa_pkg;
    typedef enum logic [2:0] {S_EXEC, S_LOAD, S_MUL, S_LPM, S_REFILL} cfa_state_t;
    typedef enum logic [1:0] {R_IO, R_EEP, R_SRAM, R_NONE} cfa_region_t;
    typedef enum logic [1:0] {SEC_APP, SEC_TABLE, SEC_BOOT} cfa_sect_t;
    typedef struct packed {
        logic [23:0] addr;
        logic [23:0] wdata;
        logic [1:0] size;
        logic we;
        logic re;
        logic direct;
    } cfa_dreq_t;
    typedef struct packed {
        logic io;
        logic eep;
        logic sram;
        logic none;
    } cfa_dsel_t;
    typedef struct packed {
        logic v;
        logic n;
        logic z;
        logic c;
    } cfa_flags_t;
    typedef struct packed {
        logic [1:0] boot;
        logic [1:0] table_sec;
        logic [1:0] app;
    } cfa_lock_t;
    typedef struct packed {
        logic we;
        logic [23:0] addr;
        logic [15:0] wdata;
    } cfa_flash_t;
endpackage : cfa_pkg

// ==== hdl/cfa_core.sv ====
// processor core: prefetching fetch path, register file, alu, multiplier and data decoder
`timescale 1ns/1ps
`default_nettype none
`include "cfa_consts.svh"

module cfa_core #(
    parameter logic [23:0] SRAM_LAST = 24'h002fff,
    parameter logic [23:0] TABLE_START = 24'h003000,
    parameter logic [23:0] BOOT_START = 24'h003800
) (
    input wire logic I_CLK,
    input wire logic I_RST_B,
    input wire logic [15:0] I_PDATA,
    input wire logic [23:0] I_DRDATA,
    input wire cfa_pkg::cfa_lock_t I_LOCK,
    output logic [23:0] O_PADDR,
    output cfa_pkg::cfa_dreq_t O_DREQ,
    output cfa_pkg::cfa_dsel_t O_DSEL,
    output cfa_pkg::cfa_flash_t O_FLASH,
    output cfa_pkg::cfa_flags_t O_SREG
);

    ////////////////////////////////////////////////////////////////////////
    // decoding helpers

    // window decode, shared by loads and stores; direct i/o sets the io select itself
    function automatic cfa_pkg::cfa_region_t region(input logic [23:0] a);
        if (a <= `CFA_IO_LAST) begin
            region = cfa_pkg::R_IO;
        end else if (a >= `CFA_EEP_FIRST && a <= `CFA_EEP_LAST) begin
            region = cfa_pkg::R_EEP;
        end else if (a >= `CFA_SRAM_FIRST && a <= SRAM_LAST) begin
            region = cfa_pkg::R_SRAM;
        end else begin
            region = cfa_pkg::R_NONE;
        end
    endfunction : region

    function automatic cfa_pkg::cfa_dsel_t selects(input logic [23:0] a);
        cfa_pkg::cfa_region_t r;
        r = region(a);
        selects.io = (r == cfa_pkg::R_IO);
        selects.eep = (r == cfa_pkg::R_EEP);
        selects.sram = (r == cfa_pkg::R_SRAM);
        selects.none = (r == cfa_pkg::R_NONE);
    endfunction : selects

    // program word address to flash section
    function automatic cfa_pkg::cfa_sect_t section(input logic [23:0] wa);
        if (wa >= BOOT_START) begin
            section = cfa_pkg::SEC_BOOT;
        end else if (wa >= TABLE_START) begin
            section = cfa_pkg::SEC_TABLE;
        end else begin
            section = cfa_pkg::SEC_APP;
        end
    endfunction : section

    function automatic logic [1:0] lock_of(input cfa_pkg::cfa_sect_t s, input cfa_pkg::cfa_lock_t l);
        case (s)
            cfa_pkg::SEC_BOOT: lock_of = l.boot;
            cfa_pkg::SEC_TABLE: lock_of = l.table_sec;
            default: lock_of = l.app;
        endcase
    endfunction : lock_of

    ////////////////////////////////////////////////////////////////////////
    // state

    logic [7:0] rf_q [32];
    logic [7:0] rf_d [32];
    cfa_pkg::cfa_state_t state_q, state_d;
    logic [15:0] ir_q, ir_d;
    logic [23:0] pc_q, pc_d;
    logic [23:0] paddr_q, paddr_d;
    logic [7:0] ramp_q, ramp_d;
    cfa_pkg::cfa_flags_t flags_q, flags_d;
    cfa_pkg::cfa_dreq_t dreq_q, dreq_d;
    cfa_pkg::cfa_dsel_t dsel_q, dsel_d;
    cfa_pkg::cfa_flash_t fl_q, fl_d;
    logic [4:0] dst_q, dst_d;
    logic [1:0] lsize_q, lsize_d;
    logic lzero_q, lzero_d;
    logic [15:0] prod_q, prod_d;

    ////////////////////////////////////////////////////////////////////////
    // instruction fields

    logic [3:0] op;
    logic [4:0] rd, rr, rdh;
    logic [7:0] a, b, kimm;
    logic [1:0] ps, md, sz;
    logic [23:0] cur_pc, jmp_pc;
    logic [4:0] plo;
    logic [15:0] ptr;
    logic [23:0] base, ea;
    logic [8:0] sum;
    logic [7:0] res;
    logic wr_res, upd_flags, cy, ov;
    logic [23:0] zword;

    assign op = ir_q[15:12];
    assign rd = ir_q[9:5];
    assign rr = ir_q[4:0];
    assign rdh = {1'b1, ir_q[11:8]};
    assign kimm = ir_q[7:0];
    assign ps = ir_q[11:10];
    assign md = ir_q[4:3];
    // size code 0..2 means 1..3 bytes; code 3 folds to 3 bytes
    assign sz = (md == 2'h3) ? 2'h0 : ((ir_q[1:0] == 2'h3) ? 2'h2 : ir_q[1:0]);
    assign cur_pc = pc_q - 24'h000001;
    assign jmp_pc = pc_q + {{12{ir_q[11]}}, ir_q[11:0]};
    // pointer pairs: low byte at the lower register index
    assign plo = `CFA_PTR_BASE + {2'h0, ps, 1'b0};
    assign ptr = {rf_q[plo + 5'h01], rf_q[plo]};
    assign base = {ramp_q, ptr};
    assign zword = {1'b0, ramp_q, rf_q[5'h1f], rf_q[5'h1e][7:1]};
    assign a = rf_q[(op == `CFA_OP_LDI || op == `CFA_OP_SUBI) ? rdh : rd];
    assign b = (op == `CFA_OP_SUBI) ? kimm : rf_q[rr];

    // effective data address for the five modes
    always_comb begin
        if (ps == 2'h3) begin
            ea = {ramp_q, I_PDATA};
        end else if (md == 2'h2) begin
            ea = base - {22'h0, sz} - 24'h000001;
        end else if (md == 2'h3) begin
            ea = base + {21'h0, ir_q[2:0]};
        end else begin
            ea = base;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // alu, single cycle
    always_comb begin
        sum = 9'h000;
        res = a;
        cy = flags_q.c;
        ov = flags_q.v;
        wr_res = 1'b0;
        upd_flags = 1'b0;
        case (op)
            `CFA_OP_ADD: begin
                sum = {1'b0, a} + {1'b0, b};
                res = sum[7:0];
                cy = sum[8];
                ov = (a[7] == b[7]) && (res[7] != a[7]);
                wr_res = 1'b1;
                upd_flags = 1'b1;
            end
            `CFA_OP_SUB, `CFA_OP_SUBI: begin
                sum = {1'b0, a} - {1'b0, b};
                res = sum[7:0];
                cy = sum[8];
                ov = (a[7] != b[7]) && (res[7] != a[7]);
                wr_res = 1'b1;
                upd_flags = 1'b1;
            end
            `CFA_OP_AND: begin
                res = a & b;
                ov = 1'b0;
                wr_res = 1'b1;
                upd_flags = 1'b1;
            end
            `CFA_OP_EOR: begin
                res = a ^ b;
                ov = 1'b0;
                wr_res = 1'b1;
                upd_flags = 1'b1;
            end
            `CFA_OP_LDI: begin
                res = kimm;
                wr_res = 1'b1;
            end
            `CFA_OP_UNARY: begin
                wr_res = 1'b1;
                upd_flags = 1'b1;
                case (ir_q[1:0])
                    2'h0: begin
                        res = a + 8'h01;
                        ov = (res == 8'h80);
                    end
                    2'h1: begin
                        res = a - 8'h01;
                        ov = (res == 8'h7f);
                    end
                    2'h2: begin
                        res = ~a;
                        cy = 1'b1;
                        ov = 1'b0;
                    end
                    default: begin
                        res = {1'b0, a[7:1]};
                        cy = a[0];
                        ov = a[0];
                    end
                endcase
            end
            default: begin
                res = a;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // sequencing, register file and bus requests
    always_comb begin
        rf_d = rf_q;
        state_d = state_q;
        ir_d = ir_q;
        pc_d = pc_q;
        ramp_d = ramp_q;
        flags_d = flags_q;
        dreq_d = '0; // strobes last one cycle
        dsel_d = '0;
        fl_d = '0;
        dst_d = dst_q;
        lsize_d = lsize_q;
        lzero_d = 1'b0;
        prod_d = prod_q;
        case (state_q)
            cfa_pkg::S_EXEC: begin
                // default: take the prefetched word while this one executes
                ir_d = I_PDATA;
                pc_d = pc_q + 24'h000001;
                if (wr_res) begin
                    rf_d[(op == `CFA_OP_LDI || op == `CFA_OP_SUBI) ? rdh : rd] = res;
                end
                if (upd_flags) begin
                    flags_d.c = cy;
                    flags_d.v = ov;
                    flags_d.n = res[7];
                    flags_d.z = (res == 8'h00);
                end
                case (op)
                    `CFA_OP_MUL: begin
                        prod_d = {8'h00, a} * {8'h00, b};
                        ir_d = ir_q;
                        pc_d = pc_q;
                        state_d = cfa_pkg::S_MUL;
                    end
                    `CFA_OP_LOAD, `CFA_OP_STORE: begin
                        // data bus runs beside the fetch bus in the same cycle
                        dreq_d.addr = ea;
                        dreq_d.size = sz;
                        dreq_d.we = (op == `CFA_OP_STORE);
                        dreq_d.re = (op == `CFA_OP_LOAD);
                        dreq_d.wdata = {rf_q[rd + 5'h02], rf_q[rd + 5'h01], rf_q[rd]};
                        dsel_d = selects(ea);
                        if (ps != 2'h3 && md == 2'h1) begin
                            {rf_d[plo + 5'h01], rf_d[plo]} = ptr + {14'h0, sz} + 16'h0001;
                        end
                        if (ps != 2'h3 && md == 2'h2) begin
                            {rf_d[plo + 5'h01], rf_d[plo]} = ea[15:0];
                        end
                        if (op == `CFA_OP_LOAD) begin
                            dst_d = rd;
                            lsize_d = sz;
                            ir_d = ir_q;
                            pc_d = (ps == 2'h3) ? pc_q + 24'h000001 : pc_q;
                            state_d = cfa_pkg::S_LOAD;
                        end else if (ps == 2'h3) begin
                            // address word was the prefetch: skip it
                            ir_d = `CFA_NOP;
                        end
                    end
                    `CFA_OP_IO: begin
                        // six address bits cannot leave the low 64 locations
                        dreq_d.addr = {18'h0, ir_q[10:5]};
                        dreq_d.direct = 1'b1;
                        dreq_d.wdata = {16'h0000, rf_q[rr]};
                        dsel_d.io = 1'b1;
                        if (ir_q[11]) begin
                            if (ir_q[10:5] == `CFA_RAMP_IO) begin
                                ramp_d = rf_q[rr];
                                dreq_d.direct = 1'b0;
                                dsel_d.io = 1'b0;
                            end else begin
                                dreq_d.we = 1'b1;
                            end
                        end else begin
                            dreq_d.re = 1'b1;
                            dst_d = rr;
                            lsize_d = 2'h0;
                            ir_d = ir_q;
                            pc_d = pc_q;
                            state_d = cfa_pkg::S_LOAD;
                        end
                    end
                    `CFA_OP_LPM: begin
                        dst_d = rd;
                        lsize_d = 2'h0;
                        // read/write lock bit set means a code of 2 or 3
                        lzero_d = (lock_of(section(zword), I_LOCK) > 2'h1) &&
                            (section(zword) != section(cur_pc));
                        ir_d = ir_q;
                        pc_d = pc_q;
                        state_d = cfa_pkg::S_LPM;
                    end
                    `CFA_OP_SPM: begin
                        // only boot code may touch application or table flash
                        fl_d.we = (section(cur_pc) == cfa_pkg::SEC_BOOT) &&
                            (section(zword) != cfa_pkg::SEC_BOOT) &&
                            (lock_of(section(zword), I_LOCK) == 2'h0);
                        fl_d.addr = zword;
                        fl_d.wdata = {rf_q[5'h01], rf_q[5'h00]};
                    end
                    `CFA_OP_JMP: begin
                        pc_d = jmp_pc;
                        ir_d = `CFA_NOP; // flush the wrong-path prefetch
                    end
                    `CFA_OP_BREQ: begin
                        if (flags_q.z) begin
                            pc_d = jmp_pc;
                            ir_d = `CFA_NOP;
                        end
                    end
                    default: begin
                    end
                endcase
            end
            cfa_pkg::S_LOAD: begin
                // all bytes of a wide register land together
                rf_d[dst_q] = I_DRDATA[7:0];
                if (lsize_q != 2'h0) begin
                    rf_d[dst_q + 5'h01] = I_DRDATA[15:8];
                end
                if (lsize_q == 2'h2) begin
                    rf_d[dst_q + 5'h02] = I_DRDATA[23:16];
                end
                ir_d = I_PDATA;
                pc_d = pc_q + 24'h000001;
                state_d = cfa_pkg::S_EXEC;
            end
            cfa_pkg::S_MUL: begin
                rf_d[5'h00] = prod_q[7:0];
                rf_d[5'h01] = prod_q[15:8];
                flags_d.c = prod_q[15];
                flags_d.z = (prod_q == 16'h0000);
                ir_d = I_PDATA;
                pc_d = pc_q + 24'h000001;
                state_d = cfa_pkg::S_EXEC;
            end
            cfa_pkg::S_LPM: begin
                // program bus is borrowed for one cycle, so fetch is refilled
                rf_d[dst_q] = lzero_q ? 8'h00 : (rf_q[5'h1e][0] ? I_PDATA[15:8] : I_PDATA[7:0]);
                state_d = cfa_pkg::S_REFILL;
            end
            cfa_pkg::S_REFILL: begin
                ir_d = I_PDATA;
                pc_d = pc_q + 24'h000001;
                state_d = cfa_pkg::S_EXEC;
            end
            default: begin
                state_d = cfa_pkg::S_EXEC;
            end
        endcase
    end

    // fetch address: the program counter, except while lpm borrows the bus
    always_comb begin
        paddr_d = pc_d;
        if (state_q == cfa_pkg::S_EXEC && op == `CFA_OP_LPM) begin
            paddr_d = zword;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            state_q <= cfa_pkg::S_EXEC;
            ir_q <= `CFA_NOP;
            pc_q <= `CFA_PC_RST;
            paddr_q <= `CFA_PC_RST;
            ramp_q <= 8'h00;
            flags_q <= '0;
            dreq_q <= '0;
            dsel_q <= '0;
            fl_q <= '0;
            dst_q <= 5'h00;
            lsize_q <= 2'h0;
            lzero_q <= 1'b0;
            prod_q <= 16'h0000;
        end else begin
            state_q <= state_d;
            ir_q <= ir_d;
            pc_q <= pc_d;
            paddr_q <= paddr_d;
            ramp_q <= ramp_d;
            flags_q <= flags_d;
            dreq_q <= dreq_d;
            dsel_q <= dsel_d;
            fl_q <= fl_d;
            dst_q <= dst_d;
            lsize_q <= lsize_d;
            lzero_q <= lzero_d;
            prod_q <= prod_d;
        end
    end

    // register file cells, one flop group per working register
    genvar gi;
    generate
        for (gi = 0; gi < 32; gi++) begin : g_rf
            always_ff @(posedge I_CLK or negedge I_RST_B) begin
                if (!I_RST_B) begin
                    rf_q[gi] <= 8'h00;
                end else begin
                    rf_q[gi] <= rf_d[gi];
                end
            end
        end
    endgenerate

    assign O_PADDR = paddr_q;
    assign O_DREQ = dreq_q;
    assign O_DSEL = dsel_q;
    assign O_FLASH = fl_q;
    assign O_SREG = flags_q;

endmodule : cfa_core
`default_nettype wire

// ==== tb/cfa_monitor.sv ====
// checker of the data decode, strobes and flash write guard
`timescale 1ns/1ps
`default_nettype none
module cfa_monitor #(
    parameter logic [23:0] SRAM_LAST = 24'h002fff,
    parameter logic [23:0] TABLE_START = 24'h003000,
    parameter logic [23:0] BOOT_START = 24'h003800
) (
    input wire logic I_CLK,
    input wire logic I_RST_B,
    input wire cfa_pkg::cfa_lock_t I_LOCK,
    input wire cfa_pkg::cfa_dreq_t O_DREQ,
    input wire cfa_pkg::cfa_dsel_t O_DSEL,
    input wire cfa_pkg::cfa_flash_t O_FLASH
);
    logic acc;
    // any data access, read or write
    assign acc = O_DREQ.re | O_DREQ.we;
    default clocking @(posedge I_CLK); endclocking
    default disable iff (!I_RST_B);
    ////////////////////////////////////////
    a_idle_quiet: assert property (!acc |-> O_DSEL == 4'h0)
        else $error("select while idle");
    a_io_window: assert property (acc && O_DREQ.addr <= 24'h000fff |-> O_DSEL == 4'h8)
        else $error("io window not selected");
    a_eep_window: assert property (acc && O_DREQ.addr inside {[24'h001000:24'h001fff]} |-> O_DSEL == 4'h4)
        else $error("eeprom window not selected");
    a_sram_window: assert property (acc && O_DREQ.addr inside {[24'h002000:SRAM_LAST]} |-> O_DSEL == 4'h2)
        else $error("sram window not selected");
    a_unmapped_none: assert property (acc && O_DREQ.addr > SRAM_LAST |-> O_DSEL == 4'h1)
        else $error("unmapped address selected something");
    a_direct_low: assert property (O_DREQ.direct |-> acc && O_DREQ.addr <= 24'h00003f)
        else $error("direct io outside low 64");
    a_whole_access: assert property (acc |-> O_DREQ.size <= 2'd2 ##1 !(O_DREQ.re && $past(O_DREQ.re)))
        else $error("multi byte access split or bad size");
    a_flash_guard: assert property (O_FLASH.we |-> O_FLASH.addr < BOOT_START && (O_FLASH.addr < TABLE_START ?
        I_LOCK.app == 2'b00 : I_LOCK.table_sec == 2'b00))
        else $error("flash write into locked section");
    a_flash_pulse: assert property ($rose(O_FLASH.we) |=> !O_FLASH.we)
        else $error("flash strobe longer than a cycle");
endmodule : cfa_monitor
bind cfa_core cfa_monitor #(.SRAM_LAST(SRAM_LAST), .TABLE_START(TABLE_START), .BOOT_START(BOOT_START)) u_mon (
    .I_CLK(I_CLK), .I_RST_B(I_RST_B), .I_LOCK(I_LOCK), .O_DREQ(O_DREQ), .O_DSEL(O_DSEL), .O_FLASH(O_FLASH));
`default_nettype wire

// ==== tb/cfa_mem_model.sv ====
// program flash and data memory seen from the core's buses
`timescale 1ns/1ps
`default_nettype none
module cfa_mem_model (
    input wire logic i_clk,
    input wire logic [23:0] i_paddr,
    input wire cfa_pkg::cfa_dreq_t i_dreq,
    output logic [15:0] o_pdata,
    output logic [23:0] o_drdata
);
    logic [15:0] prog [0:255];
    logic [7:0] data [0:65535];
    logic [23:0] junk_q = 24'h5a5a5a;
    logic [15:0] a;
    // flash answers in the same cycle; data bus shows junk when not read
    assign a = i_dreq.addr[15:0];
    assign o_pdata = prog[i_paddr[7:0]];
    assign o_drdata = i_dreq.re ? {data[a + 16'h2], data[a + 16'h1], data[a]} : junk_q;
    // stores land all bytes on the same edge, lowest byte at the lowest address
    always @(posedge i_clk) begin
        junk_q <= ~junk_q;
        if (i_dreq.we) begin
            for (int i = 0; i <= int'(i_dreq.size); i++) begin
                data[a + 16'(i)] <= i_dreq.wdata[8 * i +: 8];
            end
        end
    end
endmodule : cfa_mem_model
`default_nettype wire

// ==== tb/tb.sv ====
// self-checking bench of the core
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    cfa_pkg::cfa_lock_t lock = '0;
    logic [15:0] pdata;
    logic [23:0] drdata;
    logic [23:0] paddr;
    cfa_pkg::cfa_dreq_t dreq;
    cfa_pkg::cfa_dsel_t dsel;
    cfa_pkg::cfa_flash_t flash;
    cfa_pkg::cfa_flags_t sreg;
    int n_errors = 0;
    int checks = 0;
    int cyc = 0;
    int nfw = 0;
    logic [15:0] fw_q;
    logic [3:0] seen_q = 4'h0;
    initial forever #50 clk = ~clk;
    // boot area moved low so a short jump reaches it
    cfa_core #(.TABLE_START(24'h000040), .BOOT_START(24'h000080)) dut (.I_CLK(clk), .I_RST_B(rst_b),
        .I_PDATA(pdata), .I_DRDATA(drdata), .I_LOCK(lock), .O_PADDR(paddr), .O_DREQ(dreq),
        .O_DSEL(dsel), .O_FLASH(flash), .O_SREG(sreg));
    cfa_mem_model mem (.i_clk(clk), .i_paddr(paddr), .i_dreq(dreq), .o_pdata(pdata), .o_drdata(drdata));
    ////////////////////////////////////////
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    function automatic logic [3:0] region(input logic [23:0] ad);
        if (ad <= 24'h000fff) return 4'h8;
        if (ad <= 24'h001fff) return 4'h4;
        if (ad <= 24'h002fff) return 4'h2;
        return 4'h1;
    endfunction : region
    task automatic end_of_test();
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : end_of_test
    // watch every access and flash write, and cut a hang short
    always @(negedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_errors++;
            $display("BAD %0t timeout", $time);
            end_of_test();
        end
        if (rst_b && (dreq.re || dreq.we)) begin
            chk({20'h0, dsel}, {20'h0, region(dreq.addr)});
            seen_q = seen_q | region(dreq.addr);
        end
        if (rst_b && flash.we) begin
            nfw++;
            chk(flash.addr, (lock.app == 2'b00 && nfw == 1) ? 24'h000008 : 24'h000048);
            fw_q = flash.wdata;
        end
    end
    ////////////////////////////////////////
    // reset held 8 cycles; program memory cleared meanwhile
    task automatic halt();
        @(posedge clk) rst_b <= 1'b0;
        foreach (mem.prog[i]) mem.prog[i] = 16'h0000;
        repeat (8) @(posedge clk);
    endtask : halt
    task automatic load(input int base, input logic [15:0] w[]);
        foreach (w[i]) mem.prog[base + i] = w[i];
    endtask : load
    task automatic go(input int n);
        @(posedge clk) rst_b <= 1'b1;
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask : go
    ////////////////////////////////////////
    // add overflows into the sign, then pointer stores and a multiply
    task automatic t_alu();
        halt();
        load(0, '{16'h507f, 16'h5101, 16'h1211, 16'h5a00, 16'h5b20, 16'ha208, 16'h8211, 16'ha001, 16'hefff});
        go(0);
        for (int k = 1; k <= 4; k++) begin
            @(posedge clk);
            @(negedge clk);
            chk(paddr, 24'(k));
        end
        chk({20'h0, sreg}, 24'hc);
        repeat (20) @(negedge clk);
        chk({16'h0, mem.data[16'h2000]}, 24'h80);
        chk({8'h0, mem.data[16'h2002], mem.data[16'h2001]}, 24'h0080);
        chk({20'h0, sreg}, 24'hc);
    endtask : t_alu
    // loads across every window, a 24-bit copy and a direct io read
    task automatic t_map();
        halt();
        seen_q = 4'h0;
        mem.data[16'h2000] = 8'h11;
        mem.data[16'h2001] = 8'h22;
        mem.data[16'h2002] = 8'h33;
        load(0, '{16'h9c80, 16'h0010, 16'h9c80, 16'h0800, 16'h9c80, 16'h1000, 16'h9c80, 16'h1fff, 16'h9c42,
            16'h2000, 16'h9ca0, 16'h3000, 16'hac42, 16'h2010, 16'hb0a3, 16'hefff});
        go(40);
        chk({mem.data[16'h2012], mem.data[16'h2011], mem.data[16'h2010]}, 24'h332211);
        chk({20'h0, seen_q}, 24'hf);
    endtask : t_map
    // self-programming from app and boot under several lock settings
    task automatic t_spm();
        logic [5:0] tbl [4] = '{6'h00, 6'h01, 6'h08, 6'h30};
        int exp;
        foreach (tbl[j]) begin
            halt();
            lock <= tbl[j];
            nfw = 0;
            exp = int'(tbl[j][1:0] == 2'b00) + int'(tbl[j][3:2] == 2'b00);
            load(0, '{16'h5012, 16'h5110, 16'h8211, 16'h5e10, 16'h5f00, 16'hd000, 16'he079});
            load(128, '{16'hd000, 16'h5e90, 16'hd000, 16'hc0c0, 16'hb8a6, 16'hefff});
            load(72, '{16'h7e5a});
            go(30);
            chk(24'(nfw), 24'(exp));
            chk({8'h0, fw_q}, 24'h0120);
            chk({16'h0, mem.data[16'h0005]}, tbl[j][3] ? 24'h000000 : 24'h00005a);
        end
    endtask : t_spm
    initial begin
        t_alu();
        t_map();
        t_spm();
        end_of_test();
    end
endmodule : tb
`default_nettype wire
